/* File: core/sso_pkg.sv */
package sso_pkg;

  // widths of the internal quantities and settings
  localparam int unsigned POS_W   = 24;  // accumulated position error count, magnitude
  localparam int unsigned SPD_W   = 16;  // speeds in r/min, signed two's complement
  localparam int unsigned WSEL_W  = 8;   // warning selection mask width
  localparam int unsigned OSEL_W  = 5;   // output selection code width
  localparam int unsigned N_TERM  = 4;   // general-purpose output terminals

  // condition selection codes for positioning completion
  localparam logic [1:0] PCOND_PLAIN    = 2'h0;  // error within range only
  localparam logic [1:0] PCOND_NO_CMD   = 2'h1;  // and no position command
  localparam logic [1:0] PCOND_ZERO_SPD = 2'h2;  // and no command and zero speed
  localparam logic [1:0] PCOND_CMD_HOLD = 2'h3;  // and no command, latched

  // output selection codes, one flag per code, zero means unassigned
  localparam logic [4:0] OSEL_NONE   = 5'h00;
  localparam logic [4:0] OSEL_POS1   = 5'h01;
  localparam logic [4:0] OSEL_POS2   = 5'h02;
  localparam logic [4:0] OSEL_ROT    = 5'h03;
  localparam logic [4:0] OSEL_TLIM   = 5'h04;
  localparam logic [4:0] OSEL_ZSPD   = 5'h05;
  localparam logic [4:0] OSEL_VMATCH = 5'h06;
  localparam logic [4:0] OSEL_WARN_1 = 5'h07;
  localparam logic [4:0] OSEL_WARN_2 = 5'h08;
  localparam logic [4:0] OSEL_PCMD   = 5'h09;
  localparam logic [4:0] OSEL_VLIM   = 5'h0a;
  localparam logic [4:0] OSEL_ACLR   = 5'h0b;
  localparam logic [4:0] OSEL_VCMD   = 5'h0c;

  // default routing of the four terminals
  // done 1 shown, done 2 unassigned
  localparam logic [4:0] OSEL_DEF0 = OSEL_NONE;
  localparam logic [4:0] OSEL_DEF1 = OSEL_NONE;
  localparam logic [4:0] OSEL_DEF2 = OSEL_NONE;
  localparam logic [4:0] OSEL_DEF3 = OSEL_POS1;

  // control modes
  typedef enum logic [1:0] {
    SSO_MODE_POS,
    SSO_MODE_SPD,
    SSO_MODE_TRQ
  } sso_mode_t;

  // threshold settings travel together
  typedef struct packed {
    logic [POS_W-1:0]  pos_done_range_1;
    logic [POS_W-1:0]  pos_done_range_2;
    logic [1:0]        pos_done_condition_sel;
    logic [SPD_W-2:0]  rotation_detect_speed;
    logic [SPD_W-2:0]  zero_speed_threshold;
    logic [SPD_W-2:0]  speed_match_width;
    logic [WSEL_W-1:0] warning_select_1;
    logic [WSEL_W-1:0] warning_select_2;
  } sso_cfg_t;

  // all status flags, also the routing source
  typedef struct packed {
    logic pos_done_1;
    logic pos_done_2;
    logic rotation_detect;
    logic torque_limiting;
    logic zero_speed_flag;
    logic speed_match_flag;
    logic warning_out_1;
    logic warning_out_2;
    logic pos_cmd_flag;
    logic speed_limiting;
    logic alarm_clearable;
    logic speed_cmd_flag;
  } sso_flags_t;

endpackage : sso_pkg

/* File: core/sso_status_out.sv */
// What this block does
// - alarm output goes inactive on any error
// - alarm inactive until initial processing completes
// - position done 1 when error within range 1
// - position done 2 when error within range 2
// - done flags further qualified by condition select
// - rotation flag when speed exceeds threshold
// - torque flag while torque is clamped
// - zero speed when speed at or below threshold
// - match when speed difference within width
// - each warning output follows its selection
// - position command flag while command received
// - speed limit flag in torque mode or clamp
// - clear flag on alarm or clearable alarm
// - speed command flag in speed mode or command
// - four selectors route flags; alarm fixed
// - default routing shows done 1, not done 2
`timescale 1ns/100ps

module sso_status_out (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  // drive state
  input  wire logic                            init_done,
  input  wire logic                            error_present,
  input  wire logic                            alarm_active,
  input  wire logic                            alarm_resettable,
  input  wire sso_pkg::sso_mode_t              ctrl_mode,
  // motion quantities
  input  wire logic [sso_pkg::POS_W-1:0]       pos_error_count,
  input  wire logic signed [sso_pkg::SPD_W-1:0] motor_speed,
  input  wire logic signed [sso_pkg::SPD_W-1:0] speed_cmd,
  input  wire logic                            pos_cmd_active,
  input  wire logic                            speed_cmd_active,
  input  wire logic                            torque_clamped,
  input  wire logic                            speed_clamped,
  input  wire logic [sso_pkg::WSEL_W-1:0]      warning_cond,
  // threshold settings
  input  wire sso_pkg::sso_cfg_t               cfg,
  // terminal routing, first to last selector
  input  wire logic [sso_pkg::OSEL_W-1:0]      output_select_first,
  input  wire logic [sso_pkg::OSEL_W-1:0]      output_select_2,
  input  wire logic [sso_pkg::OSEL_W-1:0]      output_select_3,
  input  wire logic [sso_pkg::OSEL_W-1:0]      output_select_last,
  // outputs
  output logic                                 alarm_n_out,
  output logic [sso_pkg::N_TERM-1:0]           gp_out,
  output sso_pkg::sso_flags_t                  flags
);

  // magnitude of a signed speed, one bit narrower; most negative saturates
  function automatic logic [sso_pkg::SPD_W-2:0] spd_abs(
    input logic signed [sso_pkg::SPD_W:0] v
  );
    logic [sso_pkg::SPD_W:0] m;
    m = v[sso_pkg::SPD_W] ? (~v + 1'b1) : v;
    spd_abs = (m[sso_pkg::SPD_W:sso_pkg::SPD_W-1] != 2'h0) ? '1 : m[sso_pkg::SPD_W-2:0];
  endfunction : spd_abs

  // picks the flag named by one selector code; unknown codes read as off
  function automatic logic route_sel(
    input logic [sso_pkg::OSEL_W-1:0] sel,
    input sso_pkg::sso_flags_t        f
  );
    unique case (sel)
      sso_pkg::OSEL_POS1:   route_sel = f.pos_done_1;
      sso_pkg::OSEL_POS2:   route_sel = f.pos_done_2;
      sso_pkg::OSEL_ROT:    route_sel = f.rotation_detect;
      sso_pkg::OSEL_TLIM:   route_sel = f.torque_limiting;
      sso_pkg::OSEL_ZSPD:   route_sel = f.zero_speed_flag;
      sso_pkg::OSEL_VMATCH: route_sel = f.speed_match_flag;
      sso_pkg::OSEL_WARN_1: route_sel = f.warning_out_1;
      sso_pkg::OSEL_WARN_2: route_sel = f.warning_out_2;
      sso_pkg::OSEL_PCMD:   route_sel = f.pos_cmd_flag;
      sso_pkg::OSEL_VLIM:   route_sel = f.speed_limiting;
      sso_pkg::OSEL_ACLR:   route_sel = f.alarm_clearable;
      sso_pkg::OSEL_VCMD:   route_sel = f.speed_cmd_flag;
      default:              route_sel = 1'b0;
    endcase
  endfunction : route_sel

  // registered state
  sso_pkg::sso_flags_t             flags_d;       // next flag set
  logic                            alarm_n_d;     // next alarm level
  logic [sso_pkg::N_TERM-1:0]      gp_d;          // next terminal levels
  logic                            hold_q;        // latched done for held mode
  logic                            hold_d;

  // combinational helpers
  logic [sso_pkg::SPD_W-2:0]       speed_mag;     // absolute motor speed
  logic [sso_pkg::SPD_W-2:0]       diff_mag;      // |command - motor|
  logic                            in_range_1;
  logic                            in_range_2;
  logic                            qual;          // condition select gate

  // flag evaluation and routing
  always_comb begin
    speed_mag  = spd_abs({motor_speed[sso_pkg::SPD_W-1], motor_speed});
    diff_mag   = spd_abs({speed_cmd[sso_pkg::SPD_W-1], speed_cmd}
                         - {motor_speed[sso_pkg::SPD_W-1], motor_speed});
    in_range_1 = (pos_error_count <= cfg.pos_done_range_1);
    in_range_2 = (pos_error_count <= cfg.pos_done_range_2);
    hold_d     = hold_q;
    unique case (cfg.pos_done_condition_sel)
      sso_pkg::PCOND_PLAIN:    qual = 1'b1;
      sso_pkg::PCOND_NO_CMD:   qual = !pos_cmd_active;
      sso_pkg::PCOND_ZERO_SPD: qual = !pos_cmd_active && (speed_mag <= cfg.zero_speed_threshold);
      sso_pkg::PCOND_CMD_HOLD: begin
        // held until the next command, so a settling overshoot does not chatter
        if (pos_cmd_active) begin
          hold_d = 1'b0;
        end else if (in_range_1) begin
          hold_d = 1'b1;
        end
        qual = hold_d;
      end
    endcase
    if (cfg.pos_done_condition_sel != sso_pkg::PCOND_CMD_HOLD) begin
      hold_d = 1'b0;
    end
    flags_d.pos_done_1       = (in_range_1 || hold_d) && qual;
    flags_d.pos_done_2       = in_range_2 && qual;
    flags_d.rotation_detect  = (speed_mag > cfg.rotation_detect_speed);
    flags_d.torque_limiting  = torque_clamped;
    flags_d.zero_speed_flag  = (speed_mag <= cfg.zero_speed_threshold);
    flags_d.speed_match_flag = (diff_mag <= cfg.speed_match_width);
    flags_d.warning_out_1    = |(warning_cond & cfg.warning_select_1);
    flags_d.warning_out_2    = |(warning_cond & cfg.warning_select_2);
    flags_d.pos_cmd_flag     = pos_cmd_active;
    flags_d.speed_limiting   = (ctrl_mode == sso_pkg::SSO_MODE_TRQ) || speed_clamped;
    flags_d.alarm_clearable  = alarm_active || alarm_resettable;
    flags_d.speed_cmd_flag   = (ctrl_mode == sso_pkg::SSO_MODE_SPD) || speed_cmd_active;
    alarm_n_d = init_done && !error_present;
    gp_d[0] = route_sel(output_select_first, flags_d);
    gp_d[1] = route_sel(output_select_2, flags_d);
    gp_d[2] = route_sel(output_select_3, flags_d);
    gp_d[3] = route_sel(output_select_last, flags_d);
  end

  // output registers, one update per clock
  // registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags       <= '0;
      alarm_n_out <= 1'b0;
      gp_out      <= '0;
      hold_q      <= 1'b0;
    end else begin
      flags       <= flags_d;
      alarm_n_out <= alarm_n_d;
      gp_out      <= gp_d;
      hold_q      <= hold_d;
    end
  end

  // assertions
  // alarm follows error
  property p_alarm_err;
    @(posedge mclk) disable iff (!rst_n) error_present |=> !alarm_n_out;
  endproperty
  a_alarm_err: assert property (p_alarm_err) else $error("alarm active during error");

  property p_alarm_init;
    @(posedge mclk) disable iff (!rst_n)
      (init_done && !error_present) |=> alarm_n_out;
  endproperty
  a_alarm_init: assert property (p_alarm_init) else $error("alarm wrong after init");

  property p_done1;
    @(posedge mclk) disable iff (!rst_n)
      (cfg.pos_done_condition_sel == sso_pkg::PCOND_PLAIN)
      |=> (flags.pos_done_1 == $past(pos_error_count <= cfg.pos_done_range_1));
  endproperty
  a_done1: assert property (p_done1) else $error("done 1 mismatch");

  property p_done2;
    @(posedge mclk) disable iff (!rst_n)
      (cfg.pos_done_condition_sel == sso_pkg::PCOND_PLAIN)
      |=> (flags.pos_done_2 == $past(pos_error_count <= cfg.pos_done_range_2));
  endproperty
  a_done2: assert property (p_done2) else $error("done 2 mismatch");

  property p_cond;
    @(posedge mclk) disable iff (!rst_n)
      (cfg.pos_done_condition_sel == sso_pkg::PCOND_NO_CMD && pos_cmd_active)
      |=> !flags.pos_done_1 && !flags.pos_done_2;
  endproperty
  a_cond: assert property (p_cond) else $error("done during command");

  property p_rot;
    @(posedge mclk) disable iff (!rst_n)
      (speed_mag == cfg.rotation_detect_speed) |=> !flags.rotation_detect;
  endproperty
  a_rot: assert property (p_rot) else $error("rotation on at threshold");

  property p_zero_spd;
    @(posedge mclk) disable iff (!rst_n)
      (speed_mag == cfg.zero_speed_threshold) |=> flags.zero_speed_flag;
  endproperty
  a_zero_spd: assert property (p_zero_spd) else $error("zero speed off at threshold");

  // default routing shows done 1 on last terminal
  property p_route;
    @(posedge mclk) disable iff (!rst_n)
      (output_select_last == sso_pkg::OSEL_DEF3) |=> (gp_out[3] == flags.pos_done_1);
  endproperty
  a_route: assert property (p_route) else $error("default routing wrong");

  sequence s_in_reset;
    !rst_n ##1 !rst_n;
  endsequence
  property p_rst_quiet;
    @(posedge mclk) s_in_reset |-> !alarm_n_out && (gp_out == 4'h0) && (flags == '0);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active in reset");

  property p_tlim;
    @(posedge mclk) disable iff (!rst_n) torque_clamped |=> flags.torque_limiting;
  endproperty
  a_tlim: assert property (p_tlim) else $error("torque limit flag missing");

  property p_match;
    @(posedge mclk) disable iff (!rst_n)
      (diff_mag == cfg.speed_match_width) |=> flags.speed_match_flag;
  endproperty
  a_match: assert property (p_match) else $error("speed match off at width");

  property p_warn;
    @(posedge mclk) disable iff (!rst_n)
      ((warning_cond & cfg.warning_select_2) != 8'h00) |=> flags.warning_out_2;
  endproperty
  a_warn: assert property (p_warn) else $error("warning 2 missing");

  property p_pcmd;
    @(posedge mclk) disable iff (!rst_n) pos_cmd_active |=> flags.pos_cmd_flag;
  endproperty
  a_pcmd: assert property (p_pcmd) else $error("position command flag missing");

  property p_vlim;
    @(posedge mclk) disable iff (!rst_n)
      ((ctrl_mode == sso_pkg::SSO_MODE_TRQ) || speed_clamped) |=> flags.speed_limiting;
  endproperty
  a_vlim: assert property (p_vlim) else $error("speed limit flag missing");

  property p_aclr;
    @(posedge mclk) disable iff (!rst_n) alarm_resettable |=> flags.alarm_clearable;
  endproperty
  a_aclr: assert property (p_aclr) else $error("clearable flag missing");

  property p_vcmd;
    @(posedge mclk) disable iff (!rst_n)
      ((ctrl_mode == sso_pkg::SSO_MODE_SPD) || speed_cmd_active) |=> flags.speed_cmd_flag;
  endproperty
  a_vcmd: assert property (p_vcmd) else $error("speed command flag missing");

  property p_refused;
    @(posedge mclk) disable iff (!rst_n)
      ((output_select_2 == sso_pkg::OSEL_NONE) || (output_select_2 > sso_pkg::OSEL_VCMD))
      |=> !gp_out[1];
  endproperty
  a_refused: assert property (p_refused) else $error("unassigned terminal driven");

  property p_route_def;
    @(posedge mclk) disable iff (!rst_n)
      (output_select_first == sso_pkg::OSEL_DEF0) && (output_select_2 == sso_pkg::OSEL_DEF1)
      && (output_select_3 == sso_pkg::OSEL_DEF2) |=> (gp_out[2:0] == 3'h0);
  endproperty
  a_route_def: assert property (p_route_def) else $error("default spare terminal on");

  // latched done survives a quiet cycle
  sequence s_hold_arm;
    ((cfg.pos_done_condition_sel == sso_pkg::PCOND_CMD_HOLD) && !pos_cmd_active && in_range_1)
    ##1 ((cfg.pos_done_condition_sel == sso_pkg::PCOND_CMD_HOLD) && !pos_cmd_active);
  endsequence
  property p_hold_keep;
    @(posedge mclk) disable iff (!rst_n) s_hold_arm |=> flags.pos_done_1;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("latched done dropped");

  // a new command clears the latch
  sequence s_hold_drop;
    (cfg.pos_done_condition_sel == sso_pkg::PCOND_CMD_HOLD) && pos_cmd_active;
  endsequence
  property p_hold_drop;
    @(posedge mclk) disable iff (!rst_n)
      s_hold_drop |=> !flags.pos_done_1 && !flags.pos_done_2;
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("done kept in command");

endmodule : sso_status_out

/* File: test/sso_host_model.sv */
`timescale 1ns/100ps
// relay-side reader of the drive's discrete outputs
module sso_host_model (
  // clock
  input  wire logic                mclk,
  // drive outputs
  input  wire logic                alarm_n_out,
  input  wire logic [3:0]          gp_out,
  input  wire sso_pkg::sso_flags_t flags,
  // captured word
  output logic [16:0]              seen
);
  // latch mid-cycle, clear of the launching edge, as a slow input stage would
  always_ff @(negedge mclk) begin
    seen <= {alarm_n_out, gp_out, flags};
  end
endmodule : sso_host_model

/* File: test/tb.sv */
`timescale 1ns/100ps
module tb;
  logic                      mclk = 1'b0, rst_n = 1'b0, init_done = 1'b0;
  logic                      error_present = 1'b0, alarm_active = 1'b0;
  logic                      alarm_resettable = 1'b0, pos_cmd_active = 1'b0;
  logic                      speed_cmd_active = 1'b0, torque_clamped = 1'b0;
  logic                      speed_clamped = 1'b0, alarm_n_out, pend = 1'b0, hold_m = 1'b0;
  sso_pkg::sso_mode_t        ctrl_mode = sso_pkg::SSO_MODE_POS;
  logic [23:0]               pos_error_count = 24'h0;
  logic signed [15:0]        motor_speed = 16'sh0, speed_cmd = 16'sh0;
  logic [7:0]                warning_cond = 8'h0;
  sso_pkg::sso_cfg_t         cfg = '0;
  logic [4:0]                sel [4] = '{5'h0, 5'h0, 5'h0, 5'h0};
  logic [3:0]                gp_out;
  sso_pkg::sso_flags_t       flags;
  logic [16:0]               seen, exp_w, note_w;
  logic [16:0]               q [$];
  int                        failures = 0, samples_checked = 0, seed = 32'h4926;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  sso_status_out u_sso_status_out (.mclk(mclk), .rst_n(rst_n), .init_done(init_done),
    .error_present(error_present), .alarm_active(alarm_active),
    .alarm_resettable(alarm_resettable), .ctrl_mode(ctrl_mode),
    .pos_error_count(pos_error_count), .motor_speed(motor_speed), .speed_cmd(speed_cmd),
    .pos_cmd_active(pos_cmd_active), .speed_cmd_active(speed_cmd_active),
    .torque_clamped(torque_clamped), .speed_clamped(speed_clamped),
    .warning_cond(warning_cond), .cfg(cfg), .output_select_first(sel[0]),
    .output_select_2(sel[1]), .output_select_3(sel[2]), .output_select_last(sel[3]),
    .alarm_n_out(alarm_n_out), .gp_out(gp_out), .flags(flags));
  sso_host_model u_sso_host_model (.mclk(mclk), .alarm_n_out(alarm_n_out),
    .gp_out(gp_out), .flags(flags), .seen(seen));
  // one compare, counted
  task automatic check(input logic [16:0] got, input logic [16:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, got, want);
    end
  endtask : check
  // expected outputs worked out from the present inputs
  function automatic logic [16:0] model();
    sso_pkg::sso_flags_t f;
    logic [3:0]          g;
    int                  ms, d;
    logic                nq;
    ms = int'(motor_speed);
    if (ms < 0) ms = -ms;
    d = int'(speed_cmd) - int'(motor_speed);
    if (d < 0) d = -d;
    f.zero_speed_flag = ms <= int'(cfg.zero_speed_threshold);
    f.rotation_detect = ms > int'(cfg.rotation_detect_speed);
    f.speed_match_flag = d <= int'(cfg.speed_match_width);
    // condition select qualifies both done flags
    nq = (cfg.pos_done_condition_sel == 2'h0) || (!pos_cmd_active &&
         (cfg.pos_done_condition_sel == 2'h1 || f.zero_speed_flag));
    f.pos_done_1 = (pos_error_count <= cfg.pos_done_range_1) && nq;
    f.pos_done_2 = (pos_error_count <= cfg.pos_done_range_2) && nq;
    // code 3 latches done 1 until the next command; done 2 still needs range 2
    if (cfg.pos_done_condition_sel == 2'h3) begin
      if (pos_cmd_active) begin
        hold_m = 1'b0;
      end else if (pos_error_count <= cfg.pos_done_range_1) begin
        hold_m = 1'b1;
      end
      f.pos_done_1 = hold_m;
      f.pos_done_2 = hold_m && (pos_error_count <= cfg.pos_done_range_2);
    end else begin
      hold_m = 1'b0;
    end
    f.torque_limiting = torque_clamped;
    f.warning_out_1 = |(warning_cond & cfg.warning_select_1);
    f.warning_out_2 = |(warning_cond & cfg.warning_select_2);
    f.pos_cmd_flag = pos_cmd_active;
    f.speed_limiting = (ctrl_mode == sso_pkg::SSO_MODE_TRQ) || speed_clamped;
    f.alarm_clearable = alarm_active || alarm_resettable;
    f.speed_cmd_flag = (ctrl_mode == sso_pkg::SSO_MODE_SPD) || speed_cmd_active;
    // codes 1..12 pick a flag, anything else leaves the terminal off
    for (int i = 0; i < 4; i++) begin
      g[i] = (sel[i] >= 5'h01 && sel[i] <= 5'h0c) ? f[12 - int'(sel[i])] : 1'b0;
    end
    return {init_done && !error_present, g, f};
  endfunction : model
  // one cycle: note the result of the last drive, then drive anew
  task automatic step(input int md);
    logic [31:0] r;
    @(posedge mclk);
    if (pend) q.push_back(exp_w);
    #1;
    if (md > 0) begin
      r = $random(seed);
      {init_done, alarm_active, alarm_resettable, pos_cmd_active} = r[3:0];
      {speed_cmd_active, torque_clamped, speed_clamped} = r[6:4];
      error_present = r[7] & r[8];
      ctrl_mode = r[10] ? sso_pkg::SSO_MODE_TRQ :
                  (r[9] ? sso_pkg::SSO_MODE_SPD : sso_pkg::SSO_MODE_POS);
      cfg.pos_done_condition_sel = r[12:11];
      warning_cond = r[20:13];
      sel[0] = {1'b0, r[24:21]};
      cfg.warning_select_1 = r[31:24];
      r = $random(seed);
      pos_error_count = {16'h0, r[7:0]};
      cfg.pos_done_range_1 = {16'h0, r[15:8]};
      cfg.pos_done_range_2 = {16'h0, r[23:16]};
      sel[1] = {1'b0, r[27:24]};
      sel[2] = {1'b0, r[31:28]};
      r = $random(seed);
      motor_speed = {{7{r[8]}}, r[8:0]};
      speed_cmd = {{7{r[17]}}, r[17:9]};
      sel[3] = {1'b0, r[21:18]};
      cfg.warning_select_2 = r[29:22];
      r = $random(seed);
      cfg.rotation_detect_speed = {7'h0, r[7:0]};
      cfg.zero_speed_threshold = {7'h0, r[15:8]};
      cfg.speed_match_width = {7'h0, r[23:16]};
    end
    // default routing with range 1, rotation, zero speed and match thresholds met exactly at their boundaries
    if (md == 2) begin
      sel = '{sso_pkg::OSEL_DEF0, sso_pkg::OSEL_DEF1, sso_pkg::OSEL_DEF2, sso_pkg::OSEL_DEF3};
      pos_error_count = cfg.pos_done_range_1;
      cfg.zero_speed_threshold = cfg.rotation_detect_speed;
      motor_speed = -$signed({1'b0, cfg.rotation_detect_speed});
      speed_cmd = motor_speed + $signed({1'b0, cfg.speed_match_width});
    end
    exp_w = model();
    pend = 1'b1;
  endtask : step
  // result watcher on the captured word
  always @(negedge mclk) begin
    #1;
    if (q.size() > 0) begin
      note_w = q.pop_front();
      check(seen & 17'h10000, note_w & 17'h10000);
      check(seen & 17'h0f000, note_w & 17'h0f000);
      check(seen & 17'h00fc0, note_w & 17'h00fc0);
      check(seen & 17'h0003f, note_w & 17'h0003f);
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    #200_000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge mclk);
    check({alarm_n_out, gp_out, flags}, 17'h0);
    #1 rst_n = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 600; i++) step(1);
    $display("test random done");
    for (int i = 0; i < 40; i++) step(2);
    $display("test default routing done");
    // reset in mid-run clears every output at once
    step(1);
    pend = 1'b0;
    q.delete();
    // code 0 across the release clears the latch on both sides
    cfg.pos_done_condition_sel = 2'h0;
    hold_m = 1'b0;
    rst_n = 1'b0;
    #2 check({alarm_n_out, gp_out, flags}, 17'h0);
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 100; i++) step(1);
    step(0);
    for (int i = 0; i < 5 && q.size() > 0; i++) @(posedge mclk);
    if (q.size() > 0) failures++;
    $display("test second reset done");
    end_sim();
  end
endmodule : tb
